// ===== rtl/lmc_mode_ctrl.sv
// What this block does
// - Mode byte takes effect only after reset
// - Bit0 clear: sample on burst echo
// - Bit0 set: sample on own period
// - Bit1 clear: loop sets bias
// - Bit1 set: bias from temperature table
// - Bit2 selects reset-only or periodic calibration
// - Bit3 set disables driver; monitors sample in continuous mode only
// - Bit4 clear enables supply compensation
// - Bias supply compensation only when open loop
// - Bit5 clear: every burst from 100ns counts
// - Bit5 set: ignore bursts under 500ns
// - Bit6 enables tracking-error compensation
// - Bit7 clear enables PWM preboost
// - Short intervals tolerated, no update needed
`timescale 1ns/1ps
`default_nettype none
module lmc_mode_ctrl
   import lmc_pkg::*;
#(
   parameter int CONT_PERIOD = LMC_CONT_PERIOD_CYC,
   parameter int RELOAD_PERIOD = LMC_RELOAD_PERIOD_CYC
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [3:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [3:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               tx_burst_input,
   input  wire logic               burst_enable_echo,
   output logic                    driver_enable,
   output lmc_pkg::lmc_ctrl_t      ctrl
);
   import lmc_pkg::*;

   localparam int CW = 16;

   // Nonvolatile byte: reset must not clear it, or a written mode could never take effect
   logic [7:0]  mode_store_q = LMC_MODE_RESET;
   lmc_mode_t   mode_act_q;     // Byte in force since reset
   logic        boot_q;
   logic [2:0]  burst_sync_q;
   logic [2:0]  echo_sync_q;
   logic        burst_q;
   logic        echo_q;
   logic [CW-1:0] len_q;
   logic [CW-1:0] per_q;
   logic [CW-1:0] rel_q;
   logic [CW-1:0] boost_q;
   logic [15:0] sample_cnt_q;
   logic        aw_q, w_q;
   logic [3:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   // Inputs from pins: change counts once stages 2 and 3 agree
   wire burst_stable = (burst_sync_q[2] == burst_sync_q[1]);
   wire burst_now    = burst_stable ? burst_sync_q[2] : burst_q;
   wire echo_now     = (echo_sync_q[2] == echo_sync_q[1]) ? echo_sync_q[2] : echo_q;
   wire echo_fall    = echo_q & ~echo_now;
   wire burst_ok     = len_q >= CW'(mode_act_q.short_ign ? LMC_FILT_BURST_CYC : LMC_MIN_BURST_CYC);
   wire per_done     = (per_q == CW'(CONT_PERIOD - 1));
   wire rel_done     = (rel_q == CW'(RELOAD_PERIOD - 1));

   // Sample trigger: burst end in burst mode, own timer in continuous
   wire sample_burst = ~mode_act_q.cont & echo_fall & burst_ok;
   wire sample_cont  = mode_act_q.cont & per_done;
   wire sample_now   = sample_burst | sample_cont;

   // Capture of the mode byte happens one edge after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_q     <= 1'b1;
         mode_act_q <= '0;
      end else begin
         boot_q <= 1'b0;
         if (boot_q)
            mode_act_q <= lmc_mode_t'(mode_store_q);
      end
   end

   // Pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         burst_sync_q <= '0;
         echo_sync_q  <= '0;
         echo_q       <= 1'b0;
         burst_q      <= 1'b0;
      end else begin
         burst_q      <= burst_now;
         burst_sync_q <= {burst_sync_q[1:0], tx_burst_input};
         echo_sync_q  <= {echo_sync_q[1:0], burst_enable_echo};
         echo_q       <= echo_now;
      end
   end

   // Burst length, saturating so long bursts never wrap to short
   always_ff @(posedge aclk) begin
      if (!aresetn)
         len_q <= '0;
      else if (!echo_now)
         len_q <= '0;
      else if (len_q != '1)
         len_q <= len_q + CW'(1);
   end

   // Continuous sample timer and calibration reload timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_q <= '0;
         rel_q <= '0;
      end else begin
         per_q <= per_done ? '0 : per_q + CW'(1);
         rel_q <= rel_done ? '0 : rel_q + CW'(1);
      end
   end

   // Preboost window after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn)
         boost_q <= '0;
      else if (boost_q != CW'(LMC_PREBOOST_CYC))
         boost_q <= boost_q + CW'(1);
   end

   // Loop update counter, visible to software
   always_ff @(posedge aclk) begin
      if (!aresetn)
         sample_cnt_q <= '0;
      else if (sample_now)
         sample_cnt_q <= sample_cnt_q + 16'h0001;
   end

   // Control outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl          <= '0;
         driver_enable <= 1'b0;
      end else begin
         ctrl.sample        <= sample_now;
         ctrl.cal_load      <= boot_q | (mode_act_q.reload & rel_done);
         ctrl.use_table     <= mode_act_q.open_loop;
         ctrl.vcc_comp_mod  <= ~mode_act_q.no_vcc;
         ctrl.vcc_comp_bias <= ~mode_act_q.no_vcc & mode_act_q.open_loop;
         ctrl.trk_comp      <= mode_act_q.trk_err;
         ctrl.preboost      <= ~mode_act_q.no_boost & (boost_q != CW'(LMC_PREBOOST_CYC));
         // Driver enable gated by software disable; monitors keep sampling in continuous mode only, as burst mode waits for the echo
         driver_enable <= ~boot_q & ~mode_act_q.sw_dis
                          & (mode_act_q.cont | burst_now);
      end
   end

   // AXI write: address and data taken in either order
   wire wr_go = aw_q & w_q & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awaddr_q     <= '0;
         wdata_q      <= '0;
         wstrb_q      <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= LMC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == LMC_OFF_MODE) ? LMC_RESP_OKAY : LMC_RESP_SLVERR;
            if (awaddr_q == LMC_OFF_MODE && wstrb_q[0])
               mode_store_q <= wdata_q[7:0];
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI read decode
   wire [31:0] rd_word =
      (s_axi_araddr == LMC_OFF_MODE)    ? {24'h000000, mode_store_q} :
      (s_axi_araddr == LMC_OFF_STATUS)  ? {16'h0000, mode_act_q, 5'h00, burst_stable, burst_sync_q[2], echo_q} :
      (s_axi_araddr == LMC_OFF_SAMPLES) ? {16'h0000, sample_cnt_q} : 32'h00000000;
   wire rd_hit = (s_axi_araddr == LMC_OFF_MODE) | (s_axi_araddr == LMC_OFF_STATUS)
                 | (s_axi_araddr == LMC_OFF_SAMPLES);
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= LMC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? LMC_RESP_OKAY : LMC_RESP_SLVERR;
      end else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Checks
   property p_mode_hold;
      @(posedge aclk) disable iff (!aresetn) !boot_q |=> $stable(mode_act_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");
   property p_swdis;
      @(posedge aclk) disable iff (!aresetn) mode_act_q.sw_dis |=> !driver_enable;
   endproperty
   a_swdis: assert property (p_swdis) else $error("driver enabled under disable");
   property p_burst_sample;
      @(posedge aclk) disable iff (!aresetn) ctrl.sample && !$past(mode_act_q.cont) |-> $past(echo_fall);
   endproperty
   a_burst_sample: assert property (p_burst_sample) else $error("burst sample without echo end");
   property p_cont_sample;
      @(posedge aclk) disable iff (!aresetn) mode_act_q.cont && per_done |=> ctrl.sample;
   endproperty
   a_cont_sample: assert property (p_cont_sample) else $error("missed periodic sample");
   property p_short_ign;
      @(posedge aclk) disable iff (!aresetn)
         mode_act_q.short_ign && sample_burst |-> len_q >= CW'(LMC_FILT_BURST_CYC);
   endproperty
   a_short_ign: assert property (p_short_ign) else $error("short burst updated loop");
   property p_bias_comp;
      @(posedge aclk) disable iff (!aresetn) ctrl.vcc_comp_bias |-> ctrl.use_table;
   endproperty
   a_bias_comp: assert property (p_bias_comp) else $error("bias compensation in closed loop");
   property p_vcc;
      @(posedge aclk) disable iff (!aresetn) !boot_q |=> ctrl.vcc_comp_mod == !$past(mode_act_q.no_vcc);
   endproperty
   a_vcc: assert property (p_vcc) else $error("supply compensation mismatch");
   property p_reload;
      @(posedge aclk) disable iff (!aresetn) ctrl.cal_load && !$past(boot_q) |-> $past(mode_act_q.reload);
   endproperty
   a_reload: assert property (p_reload) else $error("reload without periodic mode");
endmodule : lmc_mode_ctrl
`default_nettype wire

// ===== shared/lmc_pkg.sv
`default_nettype none
package lmc_pkg;
   // Register byte addresses
   localparam logic [3:0] LMC_OFF_MODE    = 4'h0;
   localparam logic [3:0] LMC_OFF_STATUS  = 4'h4;
   localparam logic [3:0] LMC_OFF_SAMPLES = 4'h8;
   // Mode field positions
   localparam int LMC_BIT_CONT    = 0;
   localparam int LMC_BIT_OPEN    = 1;
   localparam int LMC_BIT_RELOAD  = 2;
   localparam int LMC_BIT_SWDIS   = 3;
   localparam int LMC_BIT_NOVCC   = 4;
   localparam int LMC_BIT_SHORTIG = 5;
   localparam int LMC_BIT_TRKERR  = 6;
   localparam int LMC_BIT_NOBOOST = 7;
   // Reset value of the stored mode byte
   localparam logic [7:0] LMC_MODE_RESET = 8'h00;
   // Calibration byte range
   localparam logic [3:0] LMC_CAL_FIRST = 4'h1;
   localparam logic [3:0] LMC_CAL_LAST  = 4'ha;
   // Timing, in ns and in cycles of a 50 ns clock
   localparam int LMC_CLK_NS       = 50;
   localparam int LMC_MIN_BURST_NS = 100;
   localparam int LMC_FILT_BURST_NS = 500;
   localparam int LMC_MIN_BURST_CYC  = (LMC_MIN_BURST_NS + LMC_CLK_NS - 1) / LMC_CLK_NS;
   localparam int LMC_FILT_BURST_CYC = (LMC_FILT_BURST_NS + LMC_CLK_NS - 1) / LMC_CLK_NS;
   localparam int LMC_CONT_PERIOD_CYC = 64;
   localparam int LMC_RELOAD_PERIOD_CYC = 1024;
   localparam int LMC_PREBOOST_CYC = 32;
   // Bus responses
   localparam logic [1:0] LMC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] LMC_RESP_SLVERR = 2'b10;

   // Decoded mode fields
   typedef struct packed {
      logic no_boost;
      logic trk_err;
      logic short_ign;
      logic no_vcc;
      logic sw_dis;
      logic reload;
      logic open_loop;
      logic cont;
   } lmc_mode_t;

   // Per-cycle control strobes toward the loop engine
   typedef struct packed {
      logic sample;
      logic cal_load;
      logic preboost;
      logic vcc_comp_mod;
      logic vcc_comp_bias;
      logic trk_comp;
      logic use_table;
   } lmc_ctrl_t;
endpackage : lmc_pkg
`default_nettype wire

// ===== verif/lmc_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
module lmc_drv_model #(
   parameter int ECHO_DLY = 2
) (
   input  wire logic aclk,
   input  wire logic burst_req,
   input  wire logic cont_mode,
   input  wire logic driver_enable,
   output logic      tx_burst_input,
   output logic      burst_enable_echo
);
   logic [ECHO_DLY-1:0] dly_q = '0;
   logic                tx_q  = 1'b0;
   logic                echo_q = 1'b0;
   // Host pin; continuous use keeps the burst input pinned high
   always_ff @(posedge aclk) begin
      tx_q <= burst_req | cont_mode;
   end
   // Driver echoes its own enable after an internal lag, never early
   always_ff @(posedge aclk) begin
      dly_q  <= {dly_q[ECHO_DLY-2:0], driver_enable};
      echo_q <= dly_q[ECHO_DLY-1];
   end
   assign tx_burst_input    = tx_q;
   assign burst_enable_echo = echo_q;
endmodule : lmc_drv_model
`default_nettype wire

// ===== verif/lmc_mode_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lmc_mode_ctrl_bench;
   import lmc_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, burst_req = 1'b0, cont = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tx_burst, echo, drv_en;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   lmc_ctrl_t   ctrl;
   int          n_fail = 0, total_checks = 0, n_smp = 0, n_cal = 0, got, len, c0, s1;

   always #25 aclk = ~aclk;
   // Pulse tallies, taken at the edge where each pulse stands
   always @(posedge aclk) begin
      n_smp <= n_smp + (ctrl.sample === 1'b1);
      n_cal <= n_cal + (ctrl.cal_load === 1'b1);
   end

   lmc_mode_ctrl #(.CONT_PERIOD(8), .RELOAD_PERIOD(16)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tx_burst_input(tx_burst), .burst_enable_echo(echo),
      .driver_enable(drv_en), .ctrl(ctrl));
   lmc_drv_model PEER (.aclk(aclk), .burst_req(burst_req), .cont_mode(cont),
      .driver_enable(drv_en), .tx_burst_input(tx_burst), .burst_enable_echo(echo));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // A stuck handshake ends the run instead of hanging it
   task automatic tmo(input int n);
      if (n >= 100) begin
         n_fail++;
         $display("ERROR %0t: bus handshake timed out", $time);
         end_of_test();
      end
   endtask : tmo

   task automatic wchk(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1) && n < 100);
      bready <= 1'b0;
      tmo(n);
      chk(bresp, er);
   endtask : wchk

   task automatic rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1) && n < 100);
      rready <= 1'b0;
      tmo(n);
      chk(rdata & mask, ed);
      chk(rresp, er);
   endtask : rchk

   // One burst on the host pin, then a quiet window for the loop update
   task automatic burst(input int l, output int g);
      int s0;
      @(posedge aclk);
      s0 = n_smp;
      burst_req <= 1'b1;
      repeat (l) @(posedge aclk);
      if (l >= 10) chk(drv_en, 1'b1);
      burst_req <= 1'b0;
      repeat (24) @(posedge aclk);
      chk(drv_en, 1'b0);
      g = n_smp - s0;
   endtask : burst

   // Control levels the mode byte asks for: table, tracking, bias and modulation compensation
   function automatic logic [3:0] exp_ctl(input logic [7:0] m);
      return {m[1], m[6], m[1] & !m[4], !m[4]};
   endfunction : exp_ctl

   // Reset with byte m stored; m must be in force once reset is released
   task automatic boot(input logic [7:0] m);
      c0 = n_cal;
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(ctrl.preboost, (m[7] == 1'b0));
      repeat (60) @(posedge aclk);
      chk(ctrl.preboost, 1'b0);
      chk(n_cal - c0, 1);
      chk({ctrl.use_table, ctrl.trk_comp, ctrl.vcc_comp_bias, ctrl.vcc_comp_mod}, exp_ctl(m));
      rchk(LMC_OFF_MODE, 32'hffff_ffff, {24'h000000, m}, LMC_RESP_OKAY);
      rchk(LMC_OFF_STATUS, 32'h0000_ff00, {16'h0000, m, 8'h00}, LMC_RESP_OKAY);
   endtask : boot

   initial begin
      void'($urandom(32'h07c1ccac));
      boot(8'h00);
      $display("test boot done");
      // Byte lane 0 only; upper lanes and other strobes leave the byte alone
      wchk(LMC_OFF_MODE, 32'hffff_ff5a, 4'h1, LMC_RESP_OKAY);
      rchk(LMC_OFF_MODE, 32'hffff_ffff, 32'h5a, LMC_RESP_OKAY);
      wchk(LMC_OFF_MODE, 32'h0000_3300, 4'h2, LMC_RESP_OKAY);
      rchk(LMC_OFF_MODE, 32'hffff_ffff, 32'h5a, LMC_RESP_OKAY);
      rchk(LMC_OFF_STATUS, 32'h0000_ff00, 32'h0, LMC_RESP_OKAY);
      chk({ctrl.use_table, ctrl.trk_comp, ctrl.vcc_comp_bias, ctrl.vcc_comp_mod}, 4'h1);
      wchk(4'hc, 32'hffff_ffff, 4'hf, LMC_RESP_SLVERR);
      rchk(4'hc, 32'hffff_ffff, 32'h0, LMC_RESP_SLVERR);
      $display("test registers done");
      // Corner lengths first, then random ones; each burst updates once
      for (int i = 0; i < 10; i++) begin
         len = (i == 0) ? 2 : (i == 1) ? 10 : 2 + $urandom_range(7);
         burst(len, got);
         chk(got, 1);
      end
      chk(n_cal - c0, 1);
      $display("test bursts done");
      // A too-short burst must leave the loop intact for the next one
      burst(1, got);
      burst(3, got);
      chk(got, 1);
      $display("test short burst done");
      // Byte written earlier now in force: software disable keeps the driver off
      boot(8'h5a);
      burst(3, got);
      chk(got, 0);
      $display("test second reset done");
      // Continuous mode with preboost off; host pins the burst input high
      wchk(LMC_OFF_MODE, 32'h0000_0081, 4'h1, LMC_RESP_OKAY);
      cont <= 1'b1;
      boot(8'h81);
      s1 = n_smp;
      repeat (80) @(posedge aclk);
      chk(n_smp - s1, 10);
      chk(drv_en, 1'b1);
      $display("test continuous done");
      end_of_test();
   end
endmodule : lmc_mode_ctrl_bench
`default_nettype wire
